// file: rtl/mpc_ctrl_top.sv
// control and fault registers of a six-channel motor pwm generator, apb slave
// assumes an external counter and value registers joined by the load and select strobes
//
// Summary of operation
// - soft disable forces mapped pins off; clearing waits for next pwm cycle or manual output select.
// - reload interrupt pending while reload flag and its enable are both set.
// - reload flag sets at every reload cycle start, regardless of load permission.
// - flag clears only by read-while-set then write 0, unless reload intervenes.
// - clearing reload flag removes reload interrupt, fault interrupts untouched.
// - buffered prescaler transfers only at a load cycle start with permission set.
// - software may clear load permission; hardware clears it after transfer.
// - enable clear stops generator and floats pins unless manual control active.
// - with software correction selected, select bits sampled each pwm cycle start.
// - reads return buffered rate, select and prescaler bits.
// - pair select bit 0 picks odd value register, 1 picks even.
// - prescaler divides bus clock by 1, 2, 4 or 8.
// - nonzero prescaler delays pin drive one full pwm cycle after enable.
// - dead time counts bus cycles, unaffected by prescaler.
// - dead time register takes only its first write after reset.
// - disable map picks pins forced off; takes only first write after reset.
// - fault mode bit chooses automatic or manual output recovery.
// - fault interrupt enable gates only the interrupt; outputs always disabled.
// - fault rising edge sets its flag within two cycles; cleared by acknowledge.
// - fault status shows each fault pin's present level, read only.
// - first enable causes an immediate reload, flag and interrupt.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
`include "mpc_defines.svh"
module mpc_ctrl_top #(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [CNT_W-1:0]  period_modulus,
    input  wire logic              manual_output_select,
    input  wire logic [1:0]        current_sense_config,
    input  wire logic              fault_a_in,
    input  wire logic              fault_d_in,
    input  wire logic              fault_a_ack,
    input  wire logic              fault_d_ack,
    output logic                   generator_run,
    output logic      [1:0]        active_prescale,
    output logic                   value_load,
    output logic      [2:0]        pair_value_select,
    output logic      [7:0]        dead_time_cycles,
    output logic      [5:0]        pwm_force_off,
    output logic      [5:0]        pwm_pin_oe,
    output logic                   pwm_cycle_start,
    output logic                   reload_irq,
    output logic                   fault_irq
);
    mpc_pkg::mpc_top_state_t st_ff;
    mpc_pkg::mpc_top_state_t nxt_st;

    mpc_cycle_if #(.CNT_W(CNT_W)) cyc ();

    logic       acc;
    logic       wr;
    logic       rd_done;
    logic       setup_rd;
    logic       addr_ok;
    logic       load_now;
    logic       recover_tick;
    logic [1:0] eff_prsc;
    logic [1:0] fault_event;
    logic [1:0] fault_level;
    logic [1:0] fault_hold;
    logic [5:0] mask_x;
    logic [5:0] mask_y;
    logic [7:0] rd_mux;

    initial begin
        if (ADDR_W < 8 || ADDR_W > 32) $error("mpc_ctrl_top: ADDR_W out of range");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    assign cyc.run = st_ff.en;
    assign cyc.prsc = st_ff.prsc_act;
    assign cyc.ldfq_buf = st_ff.ldfq_buf;
    assign cyc.modulus = period_modulus;

    mpc_cycle_gen #(.CNT_W(CNT_W)) u_cycle (
        .mclk (mclk),
        .rst  (rst),
        .cyc  (cyc.gen)
    );

    assign recover_tick = cyc.cycle_start | manual_output_select;

    mpc_fault_in u_fault (
        .mclk         (mclk),
        .rst          (rst),
        .fault_pin    ({fault_d_in, fault_a_in}),
        .fault_ack    ({fault_d_ack, fault_a_ack}),
        .auto_mode    ({st_ff.fctl[3], st_ff.fctl[1]}),
        .recover_tick (recover_tick),
        .fault_event  (fault_event),
        .fault_level  (fault_level),
        .fault_hold   (fault_hold)
    );

    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign rd_done = acc && !pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign addr_ok = hit(paddr, `MPC_OFF_CTRL1) || hit(paddr, `MPC_OFF_CTRL2)
                  || hit(paddr, `MPC_OFF_DEAD) || hit(paddr, `MPC_OFF_DMAP)
                  || hit(paddr, `MPC_OFF_FCTRL) || hit(paddr, `MPC_OFF_FSTAT);
    assign load_now = cyc.load_start && st_ff.load_permission;
    assign eff_prsc = load_now ? st_ff.prsc_buf : st_ff.prsc_act;

    always_comb
    begin
        rd_mux = 8'h00;
        if (hit(paddr, `MPC_OFF_CTRL1))
            rd_mux = {st_ff.dis_x, st_ff.dis_y, st_ff.irq_en, st_ff.flag,
                      2'b00, st_ff.load_permission, st_ff.en};
        else if (hit(paddr, `MPC_OFF_CTRL2))
            rd_mux = {st_ff.ldfq_buf, 1'b0, st_ff.sel_buf, st_ff.prsc_buf};
        else if (hit(paddr, `MPC_OFF_DEAD))
            rd_mux = st_ff.dead;
        else if (hit(paddr, `MPC_OFF_DMAP))
            rd_mux = st_ff.dmap;
        else if (hit(paddr, `MPC_OFF_FCTRL))
            rd_mux = {st_ff.fctl[3], st_ff.fctl[2], 4'h0, st_ff.fctl[1], st_ff.fctl[0]};
        else if (hit(paddr, `MPC_OFF_FSTAT))
            rd_mux = {fault_event[1], fault_level[1], 4'h0,
                      fault_event[0], fault_level[0]};
    end

    always_comb
    begin
        nxt_st = st_ff;
        if (setup_rd)
            nxt_st.rdata = rd_mux;

        // reload flag and clear sequence
        if (rd_done && hit(paddr, `MPC_OFF_CTRL1) && st_ff.flag)
            nxt_st.flag_armed = 1'b1;
        if (wr && hit(paddr, `MPC_OFF_CTRL1))
        begin
            nxt_st.dis_x = pwdata[`MPC_C1_BANK_X_SOFT_DISABLE];
            nxt_st.dis_y = pwdata[`MPC_C1_BANK_Y_SOFT_DISABLE];
            nxt_st.irq_en = pwdata[`MPC_C1_IRQEN];
            nxt_st.en = pwdata[`MPC_C1_EN];
            nxt_st.flag_armed = 1'b0;
            if (st_ff.flag_armed && !pwdata[`MPC_C1_FLAG])
                nxt_st.flag = 1'b0;
        end
        if (cyc.load_start)
        begin
            nxt_st.flag = 1'b1;
            nxt_st.flag_armed = 1'b0;
        end

        // load permission and transfer of buffered values
        if (load_now)
        begin
            nxt_st.prsc_act = st_ff.prsc_buf;
            nxt_st.load_permission = 1'b0;
        end
        if (wr && hit(paddr, `MPC_OFF_CTRL1))
            nxt_st.load_permission = pwdata[`MPC_C1_LOAD_PERMISSION];

        if (wr && hit(paddr, `MPC_OFF_CTRL2))
        begin
            nxt_st.ldfq_buf = pwdata[`MPC_C2_LDFQ_LSB +: 2];
            nxt_st.sel_buf = pwdata[`MPC_C2_SEL_LSB +: 3];
            nxt_st.prsc_buf = pwdata[`MPC_C2_PRSC_LSB +: 2];
        end
        if (cyc.cycle_start && current_sense_config == `MPC_ISENS_SOFT)
            nxt_st.sel_act = st_ff.sel_buf;

        // write-once dead time and disable map, then fault control
        if (wr && hit(paddr, `MPC_OFF_DEAD) && !st_ff.dead_done)
        begin
            nxt_st.dead = pwdata[7:0];
            nxt_st.dead_done = 1'b1;
        end
        if (wr && hit(paddr, `MPC_OFF_DMAP) && !st_ff.dmap_done)
        begin
            nxt_st.dmap = pwdata[7:0];
            nxt_st.dmap_done = 1'b1;
        end
        if (wr && hit(paddr, `MPC_OFF_FCTRL))
            nxt_st.fctl = {pwdata[`MPC_FC_MODE_D], pwdata[`MPC_FC_INT_D],
                           pwdata[`MPC_FC_MODE_A], pwdata[`MPC_FC_INT_A]};

        // soft disable holds until the next cycle boundary or manual output select
        if (st_ff.dis_x)
            nxt_st.dis_x_hold = 1'b1;
        else if (recover_tick)
            nxt_st.dis_x_hold = 1'b0;
        if (st_ff.dis_y)
            nxt_st.dis_y_hold = 1'b1;
        else if (recover_tick)
            nxt_st.dis_y_hold = 1'b0;

        // pin drive start
        unique case (st_ff.drv)
            mpc_pkg::DRV_OFF:
                if (st_ff.en)
                    nxt_st.drv = (eff_prsc != 2'h0) ? mpc_pkg::DRV_WAIT : mpc_pkg::DRV_ON;
            mpc_pkg::DRV_WAIT:
                if (cyc.cycle_start)
                    nxt_st.drv = mpc_pkg::DRV_ON;
            mpc_pkg::DRV_ON:
                nxt_st.drv = mpc_pkg::DRV_ON;
        endcase
        if (!st_ff.en)
            nxt_st.drv = mpc_pkg::DRV_OFF;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.drv <= mpc_pkg::DRV_OFF;
        end
        else
            st_ff <= nxt_st;
    end

    // reserved control bits are never stored, so a stray 1 cannot reach the value path

    assign mask_x = {2'b00, st_ff.dmap[3:0]};
    assign mask_y = {st_ff.dmap[5:4], 4'h0};

    assign prdata = {24'h000000, st_ff.rdata};
    assign pready = 1'b1;
    assign pslverr = acc && !addr_ok;
    assign generator_run = st_ff.en;
    assign active_prescale = st_ff.prsc_act;
    assign value_load = load_now;
    assign pair_value_select = st_ff.sel_act;
    assign dead_time_cycles = st_ff.dead;
    assign pwm_force_off = ({6{st_ff.dis_x | st_ff.dis_x_hold | fault_hold[0]}} & mask_x)
                         | ({6{st_ff.dis_y | st_ff.dis_y_hold | fault_hold[1]}} & mask_y);
    assign pwm_pin_oe = {6{(st_ff.en && st_ff.drv == mpc_pkg::DRV_ON)
                           || manual_output_select}};
    assign pwm_cycle_start = cyc.cycle_start;
    assign reload_irq = st_ff.flag && st_ff.irq_en;
    assign fault_irq = |(fault_event & {st_ff.fctl[2], st_ff.fctl[0]});

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_flag_on_load: assert property (cyc.load_start |=> st_ff.flag)
        else $error("reload flag not set at reload cycle start");

    chk_flag_no_set: assert property (!st_ff.flag && !cyc.load_start |=> !st_ff.flag)
        else $error("reload flag set without a reload");

    chk_flag_clear_armed: assert property ($fell(st_ff.flag) |-> $past(st_ff.flag_armed))
        else $error("reload flag cleared without a prior read");

    chk_irq_with_flag: assert property ($rose(st_ff.flag) && st_ff.irq_en |-> reload_irq)
        else $error("reload interrupt missing while enabled");

    chk_irq_gated: assert property (!st_ff.irq_en |-> !reload_irq)
        else $error("reload interrupt while disabled");

    chk_irq_drops_clear: assert property ($fell(st_ff.flag) |-> !reload_irq)
        else $error("reload interrupt outlived its flag");

    chk_load_needs_load_permission: assert property (value_load |-> st_ff.load_permission ##1 !st_ff.load_permission
                                          || $past(wr))
        else $error("load permission not consumed by transfer");

    chk_load_permission_spent: assert property (value_load && !wr |=> !st_ff.load_permission)
        else $error("load permission kept after transfer");

    chk_prsc_only_load: assert property (!load_now |=> $stable(st_ff.prsc_act))
        else $error("prescaler changed outside a permitted load");

    chk_prsc_loaded: assert property (load_now |=> st_ff.prsc_act == $past(st_ff.prsc_buf))
        else $error("prescaler not transferred at load");

    chk_dead_first: assert property (wr && hit(paddr, `MPC_OFF_DEAD) && !st_ff.dead_done
                                     |=> st_ff.dead == $past(pwdata[7:0]))
        else $error("first dead time write lost");

    chk_dead_once: assert property (st_ff.dead_done |=> $stable(st_ff.dead))
        else $error("dead time rewritten after first write");

    chk_dead_locked: assert property (st_ff.dead_done |=> st_ff.dead_done)
        else $error("dead time lock lost");

    chk_dmap_once: assert property (st_ff.dmap_done |=> $stable(st_ff.dmap))
        else $error("disable map rewritten after first write");

    chk_dmap_locked: assert property (st_ff.dmap_done |=> st_ff.dmap_done)
        else $error("disable map lock lost");

    chk_pins_float: assert property (!st_ff.en && !manual_output_select |-> pwm_pin_oe == 6'h00)
        else $error("pins driven while disabled");

    chk_prsc_delay: assert property ($rose(st_ff.en) && eff_prsc != 2'h0 && !manual_output_select
                                     |=> pwm_pin_oe == 6'h00)
        else $error("pins driven before a full cycle with prescaler");

    chk_drive_wait: assert property (st_ff.drv == mpc_pkg::DRV_WAIT && !manual_output_select
                                     |-> pwm_pin_oe == 6'h00)
        else $error("pins driven while waiting for a cycle");

    chk_soft_disable: assert property (st_ff.dis_x |-> (pwm_force_off & mask_x) == mask_x)
        else $error("bank x pins not forced off");

    chk_soft_disable_y: assert property (st_ff.dis_y |-> (pwm_force_off & mask_y) == mask_y)
        else $error("bank y pins not forced off");

    chk_fault_forces: assert property (fault_hold[0] |-> (pwm_force_off & mask_x) == mask_x)
        else $error("fault a pins not forced off");

    chk_fault_irq_off: assert property (!st_ff.fctl[0] && !st_ff.fctl[2] |-> !fault_irq)
        else $error("fault interrupt while disabled");

    chk_sel_sample: assert property (cyc.cycle_start && current_sense_config == `MPC_ISENS_SOFT
                                     |=> st_ff.sel_act == $past(st_ff.sel_buf))
        else $error("select bits not sampled at cycle start");

    chk_sel_hold: assert property (!cyc.cycle_start |=> $stable(st_ff.sel_act))
        else $error("select bits changed inside a cycle");

    chk_rd_buffered: assert property (setup_rd && hit(paddr, `MPC_OFF_CTRL2)
                                      |=> st_ff.rdata[1:0] == st_ff.prsc_buf)
        else $error("control two read not from buffer");

    chk_level_read: assert property (setup_rd && hit(paddr, `MPC_OFF_FSTAT)
                                     |=> st_ff.rdata[0] == $past(fault_level[0]))
        else $error("fault status read not the pin level");
endmodule // mpc_ctrl_top

// file: rtl/mpc_defines.svh
// register offsets, field positions, reset values and mode codes of the pwm control block
// assumes byte addressing on a 32-bit apb, one register per aligned word
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH

`define MPC_OFF_CTRL1     8'h00
`define MPC_OFF_CTRL2     8'h04
`define MPC_OFF_DEAD      8'h08
`define MPC_OFF_DMAP      8'h0c
`define MPC_OFF_FCTRL     8'h10
`define MPC_OFF_FSTAT     8'h14

`define MPC_C1_BANK_X_SOFT_DISABLE       7
`define MPC_C1_BANK_Y_SOFT_DISABLE       6
`define MPC_C1_IRQEN      5
`define MPC_C1_FLAG       4
`define MPC_C1_LOAD_PERMISSION       1
`define MPC_C1_EN         0

`define MPC_C2_LDFQ_LSB   6
`define MPC_C2_SEL_LSB    2
`define MPC_C2_PRSC_LSB   0

`define MPC_FC_INT_A      0
`define MPC_FC_MODE_A     1
`define MPC_FC_INT_D      6
`define MPC_FC_MODE_D     7

`define MPC_FS_LEVEL_A    0
`define MPC_FS_EVENT_A    1
`define MPC_FS_LEVEL_D    6
`define MPC_FS_EVENT_D    7

`define MPC_RST_BYTE      8'h00
`define MPC_ISENS_SOFT    2'b00

`endif

// file: rtl/mpc_pkg.sv
// types shared by the pwm control block
// assumes nothing beyond a systemverilog tool
package mpc_pkg;

    typedef enum logic [1:0] {DRV_OFF, DRV_WAIT, DRV_ON} mpc_drv_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic       dis_x;
        logic       dis_y;
        logic       irq_en;
        logic       flag;
        logic       flag_armed;
        logic       load_permission;
        logic       en;
        logic [1:0] ldfq_buf;
        logic [2:0] sel_buf;
        logic [1:0] prsc_buf;
        logic [1:0] prsc_act;
        logic [2:0] sel_act;
        logic [7:0] dead;
        logic       dead_done;
        logic [7:0] dmap;
        logic       dmap_done;
        logic [3:0] fctl;
        logic       dis_x_hold;
        logic       dis_y_hold;
        mpc_drv_t   drv;
    } mpc_top_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
        logic [1:0] flag;
        logic [1:0] hold;
    } mpc_flt_state_t;

    // low-bit mask for a divide-by-2^code setting
    function automatic logic [2:0] mpc_div_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

endpackage

// file: rtl/mpc_cycle_if.sv
// link between the control registers and the cycle timer
// assumes both ends run on mclk
`timescale 1ns/1ns
interface mpc_cycle_if #(parameter int CNT_W = 12);
    logic             run;
    logic [1:0]       prsc;
    logic [1:0]       ldfq_buf;
    logic [CNT_W-1:0] modulus;
    logic             cycle_start;
    logic             load_start;

    modport ctrl (output run, prsc, ldfq_buf, modulus, input cycle_start, load_start);
    modport gen  (input run, prsc, ldfq_buf, modulus, output cycle_start, load_start);
endinterface

// file: rtl/mpc_cycle_gen.sv
// prescaler, pwm cycle timer and load cycle scheduler
// assumes an active modulus from the value registers and a same-clock run level
`timescale 1ns/1ns
module mpc_cycle_gen #(
    parameter int CNT_W = 12
) (
    input  wire logic   mclk,
    input  wire logic   rst,
    mpc_cycle_if.gen    cyc
);
    typedef struct packed {
        logic [2:0]       presc;
        logic [CNT_W-1:0] cnt;
        logic [2:0]       ld_cnt;
        logic [1:0]       ldfq_act;
        logic             run_d;
    } mpc_cyc_state_t;

    mpc_cyc_state_t st_ff;
    mpc_cyc_state_t nxt_st;
    logic           tick;
    logic           ld_end;
    logic [2:0]     pmask;

    initial begin
        if (CNT_W < 2 || CNT_W > 16) $error("mpc_cycle_gen: CNT_W out of range");
    end

    always_comb
    begin
        nxt_st = st_ff;
        pmask = mpc_pkg::mpc_div_mask(cyc.prsc);
        tick = cyc.run && ((st_ff.presc & pmask) == pmask);
        cyc.cycle_start = tick && (st_ff.cnt == CNT_W'(cyc.modulus - 1'b1));
        ld_end = cyc.cycle_start && (st_ff.ld_cnt == mpc_pkg::mpc_div_mask(st_ff.ldfq_act));
        cyc.load_start = (cyc.run && !st_ff.run_d) || ld_end;
        nxt_st.run_d = cyc.run;
        if (!cyc.run)
        begin
            nxt_st.presc = 3'h0;
            nxt_st.cnt = '0;
            nxt_st.ld_cnt = 3'h0;
        end
        else
        begin
            nxt_st.presc = 3'(st_ff.presc + 3'h1);
            if (tick)
                nxt_st.cnt = cyc.cycle_start ? '0 : CNT_W'(st_ff.cnt + 1'b1);
            if (cyc.load_start)
                nxt_st.ld_cnt = 3'h0;
            else if (cyc.cycle_start)
                nxt_st.ld_cnt = 3'(st_ff.ld_cnt + 3'h1);
        end
        if (cyc.load_start)
            nxt_st.ldfq_act = cyc.ldfq_buf;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_first_enable_load: assert property ($rose(cyc.run) |-> cyc.load_start)
        else $error("no reload when the generator was first enabled");
    chk_rate_held: assert property (!cyc.load_start |=> $stable(st_ff.ldfq_act))
        else $error("reload rate changed inside a load cycle");
endmodule // mpc_cycle_gen

// file: rtl/mpc_fault_in.sv
// fault pin synchronisers, event flags and output hold with recovery
// assumes asynchronous fault pins and one-cycle acknowledge pulses
`timescale 1ns/1ns
module mpc_fault_in (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] fault_pin,
    input  wire logic [1:0] fault_ack,
    input  wire logic [1:0] auto_mode,
    input  wire logic       recover_tick,
    output logic      [1:0] fault_event,
    output logic      [1:0] fault_level,
    output logic      [1:0] fault_hold
);
    mpc_pkg::mpc_flt_state_t st_ff;
    mpc_pkg::mpc_flt_state_t nxt_st;
    logic [1:0]              rise;
    logic [1:0]              release_ok;

    always_comb
    begin
        nxt_st = st_ff;
        rise = st_ff.s2 & ~st_ff.prev;
        nxt_st.s1 = fault_pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.prev = st_ff.s2;
        nxt_st.flag = (st_ff.flag & ~fault_ack) | rise;
        release_ok = {2{recover_tick}} & ~st_ff.s2 & (auto_mode | ~st_ff.flag);
        nxt_st.hold = rise | (st_ff.hold & ~release_ok);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign fault_event = st_ff.flag | rise;
    assign fault_level = st_ff.s2;
    assign fault_hold = st_ff.hold | rise;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_event_sticky: assert property (st_ff.flag[0] && !fault_ack[0] |=> fault_event[0])
        else $error("fault event flag cleared without acknowledge");
    chk_fault_disables: assert property ($rose(fault_level[1]) |-> fault_hold[1] ##1 fault_hold[1])
        else $error("fault did not hold outputs off");
    chk_fault_a_hold: assert property ($rose(fault_level[0]) |-> fault_hold[0] ##1 fault_hold[0])
        else $error("fault a did not hold outputs off");
endmodule // mpc_fault_in

// file: tb/mpc_stage_model.sv
// power stage model: fault sense sources and pin observation
// assumes fault requests from the bench and pin controls from the block
`timescale 1ns/1ns
module mpc_stage_model (
    input  wire logic       mclk,
    input  wire logic [1:0] fault_req,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] force_off,
    output logic            fault_a,
    output logic            fault_d,
    output logic      [5:0] live_pins
);
    initial
    begin
        fault_a = 1'b0;
        fault_d = 1'b0;
    end
    // sense lines follow the stage state, changed just after an edge
    always @(posedge mclk)
    begin
        fault_a <= fault_req[0];
        fault_d <= fault_req[1];
    end
    // legs that are driven and not forced off
    assign live_pins = pin_oe & ~force_off;
endmodule // mpc_stage_model

// file: tb/mpc_ctrl_top_bench.sv
// self-checking bench of the pwm control registers over apb
// assumes the stage model and a short pwm period
`timescale 1ns/1ns
module mpc_ctrl_top_bench;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic [11:0] modulus;
    logic fa, fd, fa_ack, fd_ack, run, vload, cstart, rirq, firq, err, man;
    logic [1:0] aps, freq;
    logic [2:0] sel;
    logic [7:0] dead;
    logic [5:0] foff, oe, live;
    int fail_count, total_checks, loads, since, gap;
    mpc_ctrl_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .period_modulus(modulus),
        .manual_output_select(man), .current_sense_config(2'b00), .fault_a_in(fa),
        .fault_d_in(fd), .fault_a_ack(fa_ack), .fault_d_ack(fd_ack), .generator_run(run),
        .active_prescale(aps), .value_load(vload), .pair_value_select(sel),
        .dead_time_cycles(dead), .pwm_force_off(foff), .pwm_pin_oe(oe),
        .pwm_cycle_start(cstart), .reload_irq(rirq), .fault_irq(firq));
    mpc_stage_model stage (.mclk(mclk), .fault_req(freq), .pin_oe(oe), .force_off(foff),
        .fault_a(fa), .fault_d(fd), .live_pins(live));
    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (vload === 1'b1) loads <= loads + 1;
    // edges between two cycle starts
    always @(posedge mclk)
        if (cstart === 1'b1)
        begin
            gap <= since;
            since <= 1;
        end
        else
            since <= since + 1;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge mclk);
        end
        if (n >= 20) begin fail_count++; tally_and_finish; end
        q = prdata[7:0];
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wcyc;
        int n;
        n = 0;
        @(posedge mclk);
        while (cstart !== 1'b1 && n < 600)
        begin
            n++;
            @(posedge mclk);
        end
        if (n >= 600) begin fail_count++; tally_and_finish; end
        @(posedge mclk);
        #1;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        modulus = 12'h040; fa_ack = 0; fd_ack = 0; freq = 2'h0; loads = 0;
        man = 0; since = 0; gap = 0;
        fail_count = 0; total_checks = 0;
        repeat (16) @(posedge mclk);
        rst <= 0;
        for (int i = 0; i < 6; i++)
        begin
            apb(0, 8'(i * 4), 8'h00);
            chk(q, 8'h00);
        end
        apb(0, 8'h18, 8'h00);
        chk({7'h0, err}, 8'h01);
        apb(1, 8'h08, 8'h5a);
        apb(1, 8'h08, 8'ha5);
        apb(0, 8'h08, 8'h00);
        chk(q, 8'h5a);
        chk(dead, 8'h5a);
        apb(1, 8'h0c, 8'h3f);
        apb(1, 8'h0c, 8'h00);
        apb(0, 8'h0c, 8'h00);
        chk(q, 8'h3f);
        apb(1, 8'h04, 8'hff);
        apb(0, 8'h04, 8'h00);
        chk(q, 8'hdf);
        apb(1, 8'h04, 8'h14);
        // bits 3:2 of control one are always written as zero
        apb(1, 8'h00, 8'h22);
        apb(1, 8'h00, 8'h23);
        repeat (2) @(posedge mclk);
        #1;
        chk({2'h0, oe}, 8'h3f);
        chk({7'h0, rirq}, 8'h01);
        chk(8'(loads), 8'h01);
        apb(0, 8'h00, 8'h00);
        chk(q, 8'h31);
        apb(1, 8'h00, 8'h21);
        apb(0, 8'h00, 8'h00);
        chk(q, 8'h21);
        chk({7'h0, rirq}, 8'h00);
        wcyc;
        chk({7'h0, rirq}, 8'h01);
        chk(8'(loads), 8'h01);
        chk({5'h0, sel}, 8'h05);
        apb(1, 8'h00, 8'ha1);
        #1;
        chk({2'h0, foff}, 8'h0f);
        apb(1, 8'h00, 8'h21);
        #1;
        chk({2'h0, foff}, 8'h0f);
        wcyc;
        chk({2'h0, foff}, 8'h00);
        freq <= 2'h1;
        repeat (4) @(posedge mclk);
        #1;
        chk({2'h0, live}, 8'h30);
        chk({7'h0, firq}, 8'h00);
        apb(0, 8'h14, 8'h00);
        chk(q, 8'h03);
        apb(1, 8'h10, 8'h01);
        #1;
        chk({7'h0, firq}, 8'h01);
        @(posedge mclk);
        fa_ack <= 1;
        @(posedge mclk);
        fa_ack <= 0;
        apb(0, 8'h14, 8'h00);
        chk(q, 8'h01);
        freq <= 2'h0;
        apb(1, 8'h00, 8'h20);
        repeat (2) @(posedge mclk);
        #1;
        chk({2'h0, oe}, 8'h00);
        @(posedge mclk);
        man <= 1'b1;
        @(posedge mclk);
        #1;
        chk({2'h0, oe}, 8'h3f);
        @(posedge mclk);
        man <= 1'b0;
        apb(1, 8'h04, 8'h15);
        apb(1, 8'h00, 8'h23);
        repeat (2) @(posedge mclk);
        #1;
        chk({2'h0, oe}, 8'h00);
        chk({6'h0, aps}, 8'h01);
        chk({7'h0, run}, 8'h01);
        chk(8'(loads), 8'h02);
        wcyc;
        chk({2'h0, oe}, 8'h3f);
        wcyc;
        chk(8'(gap), 8'h80);
        tally_and_finish;
    end
endmodule // mpc_ctrl_top_bench
